// >>> design/dmr3_decode.sv
// third mode register: capture on the link clock, decoded fields on the core clock
// What this block does
// - bank group bit 0 and both bank address bits form a selector, codes 000 to 110 picking mode registers 0 to 6.
// - a command whose selector is 111 is ignored, leaving all state unchanged and giving no response.
// - address bits 10:9 give the extra write latency with CRC and mask, 00 four, 01 five, 10 six clocks, 11 reserved.
// - address bits 8:6 give the refresh granularity mode, with 011, 100 and 111 reserved.
// - bit 5 enables sensor readout, bit 4 per-device addressing, bit 3 quarter rate, bit 2 multipurpose dataflow.
`timescale 1ns/1ps
`default_nettype none
`include "dmr3_defines.svh"
module dmr3_decode
    import dmr3_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ck_link_i,
    input wire logic link_rst_n_i,
    input wire logic mode_register_set_command_i,
    input wire logic [1:0] bg_i,
    input wire logic [1:0] ba_i,
    input wire logic [17:0] addr_i,
    output logic [17:0] mode_register_three_o,
    output logic reserved_bits_set_o,
    output logic reserved_code_o,
    output logic [3:0] write_cmd_latency_o,
    output logic [2:0] refresh_mode_o,
    output logic temp_readout_en_o,
    output logic per_device_addr_en_o,
    output logic quarter_rate_o,
    output logic multipurpose_dataflow_o,
    output logic [1:0] multipurpose_read_format_o,
    output logic [1:0] multipurpose_page_select_o
);

////////////////////////////////////////////////////////////////////////////////
// link domain capture

    function automatic logic [2:0] sel_of(input logic [1:0] bg, input logic [1:0] ba);
        sel_of = {bg[0], ba};
    endfunction

    logic [17:0] link_word_ff;
    logic [17:0] nxt_link_word;
    logic link_tgl_ff;
    logic nxt_link_tgl;
    logic link_rsv_ff;
    logic nxt_link_rsv;

    always_comb
    begin
        nxt_link_word = link_word_ff;
        nxt_link_tgl = link_tgl_ff;
        nxt_link_rsv = link_rsv_ff;
        if (mode_register_set_command_i && (sel_of(bg_i, ba_i) == `DMR3_SEL_MR3))
        begin
            nxt_link_word = addr_i;
            nxt_link_tgl = ~link_tgl_ff;
            nxt_link_rsv = bg_i[1] | addr_i[`DMR3_BIT_RSV_A17] | addr_i[`DMR3_BIT_RSV_A13];
        end
    end

    always_ff @(posedge ck_link_i)
    begin
        if (!link_rst_n_i)
        begin
            link_word_ff <= `DMR3_RESET_VALUE;
            link_tgl_ff <= 1'b0;
            link_rsv_ff <= 1'b0;
        end
        else
        begin
            link_word_ff <= nxt_link_word;
            link_tgl_ff <= nxt_link_tgl;
            link_rsv_ff <= nxt_link_rsv;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// crossing: word held stable while toggle passes two flops

    logic tgl_sync;
    logic tgl_seen_ff;
    logic nxt_tgl_seen;

    dmr3_sync #(.WIDTH(1)) u_tgl_sync
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(link_tgl_ff),
        .q_o(tgl_sync)
    );

    logic load;
    assign load = tgl_sync ^ tgl_seen_ff;
    assign nxt_tgl_seen = tgl_sync;

////////////////////////////////////////////////////////////////////////////////
// core domain register

    logic [17:0] mr3_ff;
    logic [17:0] nxt_mr3;
    logic rsv_ff;
    logic nxt_rsv;

    always_comb
    begin
        nxt_mr3 = mr3_ff;
        nxt_rsv = rsv_ff;
        if (load)
        begin
            nxt_mr3 = link_word_ff;
            nxt_rsv = link_rsv_ff;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mr3_ff <= `DMR3_RESET_VALUE;
            rsv_ff <= 1'b0;
            tgl_seen_ff <= 1'b0;
        end
        else
        begin
            mr3_ff <= nxt_mr3;
            rsv_ff <= nxt_rsv;
            tgl_seen_ff <= nxt_tgl_seen;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// field decode

    dmr3_fmt_e fmt;
    dmr3_fgr_e fgr;
    logic [1:0] wcl;
    logic fgr_rsv;

    assign fmt = dmr3_fmt_e'(mr3_ff[`DMR3_FMT_HI:`DMR3_FMT_LO]);
    assign fgr = dmr3_fgr_e'(mr3_ff[`DMR3_FGR_HI:`DMR3_FGR_LO]);
    assign wcl = mr3_ff[`DMR3_WCL_HI:`DMR3_WCL_LO];

    always_comb
    begin
        fgr_rsv = 1'b0;
        unique case (fgr)
            DMR3_FGR_FIX1, DMR3_FGR_FIX2, DMR3_FGR_FIX4, DMR3_FGR_OTF12, DMR3_FGR_OTF14: fgr_rsv = 1'b0;
            DMR3_FGR_RSV3, DMR3_FGR_RSV4, DMR3_FGR_RSV7: fgr_rsv = 1'b1;
        endcase
    end

    // latency in clocks, zero when reserved
    assign write_cmd_latency_o = (wcl == 2'h3) ? 4'h0 : (`DMR3_WCL_BASE + {2'h0, wcl});
    assign refresh_mode_o = mr3_ff[`DMR3_FGR_HI:`DMR3_FGR_LO];
    // reserved codes only reported, behaviour otherwise undefined
    assign reserved_code_o = fgr_rsv | (wcl == 2'h3) | (fmt == DMR3_FMT_RSV);
    assign reserved_bits_set_o = rsv_ff;
    assign mode_register_three_o = mr3_ff;
    assign temp_readout_en_o = mr3_ff[`DMR3_BIT_TEMP];
    assign per_device_addr_en_o = mr3_ff[`DMR3_BIT_PDA];
    assign quarter_rate_o = mr3_ff[`DMR3_BIT_GEAR];
    assign multipurpose_dataflow_o = mr3_ff[`DMR3_BIT_MPR];
    assign multipurpose_read_format_o = mr3_ff[`DMR3_FMT_HI:`DMR3_FMT_LO];
    assign multipurpose_page_select_o = mr3_ff[`DMR3_PAGE_HI:`DMR3_PAGE_LO];

endmodule
`default_nettype wire

// >>> design/dmr3_defines.svh
// constants for the third mode register decode block
`ifndef DMR3_DEFINES_SVH
`define DMR3_DEFINES_SVH
`define DMR3_SEL_MR3 3'h3
`define DMR3_SEL_RCW 3'h7
`define DMR3_RESET_VALUE 18'h00000
`define DMR3_BIT_RSV_A17 17
`define DMR3_BIT_RSV_A13 13
`define DMR3_FMT_HI 12
`define DMR3_FMT_LO 11
`define DMR3_WCL_HI 10
`define DMR3_WCL_LO 9
`define DMR3_FGR_HI 8
`define DMR3_FGR_LO 6
`define DMR3_BIT_TEMP 5
`define DMR3_BIT_PDA 4
`define DMR3_BIT_GEAR 3
`define DMR3_BIT_MPR 2
`define DMR3_PAGE_HI 1
`define DMR3_PAGE_LO 0
`define DMR3_WCL_BASE 4'h4
`endif

// >>> design/dmr3_pkg.sv
// types for the third mode register decode block
package dmr3_pkg;
    typedef enum logic [1:0] {
        DMR3_FMT_SERIAL = 2'h0,
        DMR3_FMT_PARALLEL = 2'h1,
        DMR3_FMT_STAGGERED = 2'h2,
        DMR3_FMT_RSV = 2'h3
    } dmr3_fmt_e;
    typedef enum logic [2:0] {
        DMR3_FGR_FIX1 = 3'h0,
        DMR3_FGR_FIX2 = 3'h1,
        DMR3_FGR_FIX4 = 3'h2,
        DMR3_FGR_RSV3 = 3'h3,
        DMR3_FGR_RSV4 = 3'h4,
        DMR3_FGR_OTF12 = 3'h5,
        DMR3_FGR_OTF14 = 3'h6,
        DMR3_FGR_RSV7 = 3'h7
    } dmr3_fgr_e;
    typedef logic [17:0] dmr3_word_t;
endpackage

// >>> design/dmr3_sync.sv
// two flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module dmr3_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end
    assign q_o = sync_ff;
endmodule
`default_nettype wire

// >>> verif/dmr3_ctl.sv
// controller model driving mode register set commands
`timescale 1ns/1ps
`default_nettype none
module dmr3_ctl (
    input wire logic ck_i,
    output logic c_o,
    output logic [21:0] ca_o
);
    initial {c_o, ca_o} = '0;
    task automatic issue(input logic [2:0] s, input logic [17:0] w, input logic bad);
        @(negedge ck_i);
        c_o = 1'b1;
        ca_o = {bad, s, bad ? w : w & 18'h1DFFF};
        @(negedge ck_i);
        c_o = 1'b0;
        ca_o = ~ca_o;
    endtask
endmodule
`default_nettype wire

// >>> verif/dmr3_decode_properties.sv
// assertions for the mode register three decode block
`timescale 1ns/1ps
`default_nettype none
module dmr3_decode_properties (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ck_link_i,
    input wire logic link_rst_n_i,
    input wire logic mode_register_set_command_i,
    input wire logic [1:0] bg_i,
    input wire logic [1:0] ba_i,
    input wire logic [17:0] addr_i,
    input wire logic [17:0] mode_register_three_o,
    input wire logic reserved_bits_set_o,
    input wire logic reserved_code_o,
    input wire logic [3:0] write_cmd_latency_o
);
    wire [17:0] w = mode_register_three_o;
    wire c = mode_register_set_command_i;
    wire [2:0] sel = {bg_i[0], ba_i};
    wire rb = bg_i[1] | addr_i[17] | addr_i[13];
    wire rc = &w[10:9] | &w[12:11] | (w[8:6] inside {3'h3, 3'h4, 3'h7});
    sequence s_mr3; c && sel == 3'h3; endsequence
    property p_core(x);
        @(posedge clk_i) disable iff (!rst_n_i) x;
    endproperty
    property p_link(a, b);
        @(posedge ck_link_i) disable iff (!link_rst_n_i || !rst_n_i) a |=> b;
    endproperty
    chk_word_load: assert property (p_link(s_mr3, w == $past(addr_i))) else $error("no load");
    chk_word_hold: assert property (p_link(!c, $stable(w))) else $error("drift");
    chk_sel_skip: assert property (p_link(c && sel != 3'h3, $stable(w))) else $error("wrong load");
    chk_rcw_quiet: assert property (p_link(c && &sel, $stable(reserved_bits_set_o))) else $error("rcw");
    chk_rsv_flag: assert property (p_link(s_mr3, reserved_bits_set_o == $past(rb))) else $error("flag");
    chk_flag_hold: assert property (p_link(!c, $stable(reserved_bits_set_o))) else $error("flag drift");
    chk_wcl_value: assert property (p_core(write_cmd_latency_o == (&w[10:9] ? 4'h0 : 4'h4 + {2'h0, w[10:9]})))
        else $error("latency");
    chk_rsv_code: assert property (p_core(reserved_code_o == rc)) else $error("code");
endmodule
bind dmr3_decode dmr3_decode_properties dmr3_decode_properties_inst (.*);
`default_nettype wire

// >>> verif/tb_dmr3_decode.sv
// bench for the mode register three decode block
`timescale 1ns/1ps
`default_nettype none
module tb_dmr3_decode;
    logic clk_i, rst_n_i, ck_link_i, link_rst_n_i, mode_register_set_command_i, reserved_bits_set_o, xb;
    logic reserved_code_o, temp_readout_en_o, per_device_addr_en_o, quarter_rate_o, multipurpose_dataflow_o;
    logic [1:0] bg_i, ba_i, multipurpose_read_format_o, multipurpose_page_select_o;
    logic [2:0] refresh_mode_o;
    logic [3:0] write_cmd_latency_o;
    logic [17:0] addr_i, mode_register_three_o, xw;
    int num_errors = 0, n_checks = 0, cyc = 0;
    dmr3_decode dmr3_decode_inst (.*);
    dmr3_ctl dmr3_ctl_inst (.ck_i(ck_link_i), .c_o(mode_register_set_command_i), .ca_o({bg_i, ba_i, addr_i}));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        ck_link_i = 1'b0;
        #3;
        forever #80 ck_link_i = ~ck_link_i;
    end
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
            give_verdict();
    end
    function automatic logic [17:0] exp_f(input logic [17:0] w, input logic b);
        return {&w[10:9] ? 4'h0 : 4'h4 + {2'h0, w[10:9]}, w[5:2], w[12:11], w[1:0], w[8:6], b, 2'h0};
    endfunction
    task automatic cmp_w(input logic [17:0] g, input logic [17:0] e);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t %h %h", $time, g, e);
        end
    endtask
    task automatic send(input logic [2:0] s, input logic [17:0] w, input logic bad);
        dmr3_ctl_inst.issue(s, w, bad);
        if (s == 3'h3)
            {xb, xw} = {bad, bad ? w : w & 18'h1DFFF};
        repeat (8) @(negedge clk_i);
        cmp_w(mode_register_three_o, xw);
        cmp_w({write_cmd_latency_o, temp_readout_en_o, per_device_addr_en_o, quarter_rate_o, multipurpose_dataflow_o,
            multipurpose_read_format_o, multipurpose_page_select_o, refresh_mode_o, reserved_bits_set_o, 2'h0},
            exp_f(xw, xb));
        cmp_w({17'h0, reserved_code_o}, {17'h0, &xw[10:9] | &xw[12:11] | (xw[8:6] inside {3'h3, 3'h4, 3'h7})});
    endtask
    initial
    begin
        void'($urandom(32'h4DC91888));
        {rst_n_i, link_rst_n_i, xb, xw} = '0;
        repeat (12) @(negedge ck_link_i);
        @(negedge clk_i);
        {rst_n_i, link_rst_n_i} = 2'h3;
        for (int s = 0; s < 8; s++)
            send(s[2:0], 18'($urandom), 1'b1);
        $display("selectors done");
        for (int i = 0; i < 32; i++)
            send(3'h3, {7'($urandom), i[1:0], i[4:2], 6'($urandom)}, 1'b1);
        $display("codes done");
        send(3'h3, 18'h3FFFF, 1'b0);
        send(3'h3, 18'h0, 1'b0);
        $display("clean done");
        give_verdict();
    end
    task automatic give_verdict();
        num_errors += int'(cyc >= 20000);
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
endmodule
`default_nettype wire
